/* File: dv/adc_scan_mode_decoder_tb.sv */
// bench for the scan-mode decoder: host model, converter responder, queues
// assumes every conversion request is answered once by the responder
`timescale 1ns/1ns
`include "scan_params.svh"
module adc_scan_mode_decoder_tb;
  import scan_pkg::*;
  logic        core_clk_in, rst_b_in, sclk, cs_b, din, dout, cnv_start_in;
  logic        conv_done_in, clk_int, avg_en, swcnv, conv_req, fifo_wr, man, to_fifo;
  logic [1:0]  rep_sel, rst_f, pm;
  logic [11:0] conv_data_in;
  logic [15:0] fifo_data, rx;
  scan_mode_e  mode;
  chan_t       chan_sel, conv_chan, n;
  chan_t       chq[$];
  logic [15:0] rq[$], fq[$];
  int          errors, comparisons;

  adc_scan_mode_decoder adc_scan_mode_decoder_i (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_b_in(cs_b),
    .din_in(din), .dout_out(dout), .cnv_start_in(cnv_start_in), .repeat_sel_in(rep_sel),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .scan_mode_out(mode),
    .chan_sel_out(chan_sel), .clk_src_int_out(clk_int), .avg_en_out(avg_en),
    .reset_field_out(rst_f), .pm_out(pm), .swcnv_out(swcnv), .conv_req_out(conv_req),
    .conv_chan_out(conv_chan), .fifo_wr_out(fifo_wr), .fifo_data_out(fifo_data));
  spi_host_model spi_host_model_i (
    .sclk_out(sclk), .cs_b_out(cs_b), .din_out(din), .dout_in(dout), .rx_out(rx));

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // converter stand-in with a random answer delay
  always @(posedge core_clk_in)
  begin
    chan_t       e;
    logic [15:0] r;
    if (conv_req === 1'b1)
    begin
      e = (chq.size() != 0) ? chq.pop_front() : 4'hx;
      chk({12'h000, conv_chan}, {12'h000, e});
      r = {e, 12'($urandom)};
      // manual results leave on the link, scan results through the fifo port
      if (to_fifo)
        fq.push_back(r);
      else
        rq.push_back(r);
      repeat ($urandom_range(3, 0)) @(posedge core_clk_in);
      conv_done_in <= 1'b1;
      conv_data_in <= r[11:0];
      @(posedge core_clk_in);
      conv_done_in <= 1'b0;
    end
  end

  always @(posedge core_clk_in)
    if (fifo_wr === 1'b1)
      chk(fifo_data, (fq.size() != 0) ? fq.pop_front() : 16'hxxxx);

  // ch below zero: the frame triggers no manual conversion
  task automatic frame(input logic [15:0] w, input int ch);
    @(posedge core_clk_in);
    if (ch >= 0)
      chq.push_back(chan_t'(ch));
    to_fifo = (ch < 0);
    spi_host_model_i.send_word(w);
    if (man)
      chk(rx, rq.pop_front());
    man = (ch >= 0);
    repeat (12) @(posedge core_clk_in);
  endtask : frame

  task automatic mode_is(input scan_mode_e m, input chan_t c, input logic ci);
    chk({14'h0000, mode}, {14'h0000, m});
    chk({12'h000, chan_sel}, {12'h000, c});
    chk({14'h0000, clk_int, avg_en}, {14'h0000, ci, ci});
  endtask : mode_is

  task automatic drain;
    for (int i = 0; i < 4000 && chq.size() + fq.size() != 0; i++)
      @(posedge core_clk_in);
    if (chq.size() + fq.size() != 0)
    begin
      errors++;
      end_of_test();
    end
  endtask : drain

  initial
  begin
    {rst_b_in, cnv_start_in, conv_done_in, man, to_fifo} = 5'h00;
    rep_sel = 2'h0;
    conv_data_in = 12'h000;
    errors = 0;
    comparisons = 0;
    void'($urandom(18841));
    repeat (5) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    mode_is(mode_manual, 4'h0, 1'b0);
    n = chan_t'($urandom);
    frame({1'b0, 4'h1, n, 7'h00}, n);
    mode_is(mode_manual, n, 1'b0);
    frame(16'h0000, n);
    mode_is(mode_manual, n, 1'b0);
    frame({1'b0, 4'h0, ~n, 7'h5a}, n);
    chk({11'h000, rst_f, pm, swcnv}, {11'h000, 2'h2, 2'h3, 1'b1});
    mode_is(mode_manual, n, 1'b0);
    frame({1'b1, 4'h2, ~n, 7'h00}, n);
    mode_is(mode_manual, n, 1'b0);
    // unknown code: mode and channel stay, the loose bits still land
    frame({1'b0, 4'hc, ~n, 7'h48}, n);
    chk({11'h000, rst_f, pm, swcnv}, {11'h000, 2'h2, 2'h1, 1'b0});
    mode_is(mode_manual, n, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      n = chan_t'($urandom);
      rep_sel <= 2'(s);
      repeat (4 * (s + 1)) chq.push_back(n);
      frame({1'b0, 4'h2, n, 5'h00, s != 3, 1'b0}, -1);
      if (s == 3)
      begin
        cnv_start_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        cnv_start_in <= 1'b0;
      end
      drain();
      mode_is(mode_repeat, n, 1'b1);
    end
    chq.delete();
    for (int s = 0; s < 3; s++)
    begin
      n = (s == 0) ? 4'h0 : (s == 1) ? 4'hf : chan_t'($urandom);
      for (int c = 0; c <= n; c++)
        chq.push_back(chan_t'(c));
      frame({1'b0, 4'h3, n, 7'h02}, -1);
      drain();
      mode_is(mode_std_int, n, 1'b1);
    end
    end_of_test();
  end
endmodule : adc_scan_mode_decoder_tb

/* File: dv/spi_host_model.sv */
// serial host model: sends 16-bit words msb first and captures the answer
// assumes the bench calls send_word with frames well apart
`timescale 1ns/1ns
module spi_host_model (
  output logic        sclk_out,
  output logic        cs_b_out,
  output logic        din_out,
  input  wire logic   dout_in,
  output logic [15:0] rx_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    din_out  = 1'b0;
    rx_out   = 16'h0000;
  end

  // clock stands still between frames
  task automatic send_word(input logic [15:0] w);
    #3;
    cs_b_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      din_out = w[i];
      #80;
      rx_out = {rx_out[14:0], dout_in};
      sclk_out = 1'b1;
      #80;
      sclk_out = 1'b0;
    end
    cs_b_out = 1'b1;
    // released line: no stale level
    din_out = ~din_out;
  endtask : send_word
endmodule : spi_host_model

/* File: include/scan_params.svh */
// constants for the scan-mode decoder: word layout, codes, counts
// assumes 16-bit serial control words, msb first
//
// Functional notes
// - all-zero scan code keeps previous mode
// - zero code still updates bits 6:3, 1
// - manual: channel named per frame, result next frame
// - manual: external clock, one channel, no averaging
// - repeat: channel N, 4/8/12/16 results
// - repeat: internal clock, averaging, channel field
// - standard: channels 0..N ascending, internal, averaged
// - standard: last channel from channel field
// - bit 15 zero selects mode word; scan 14:11
// - channel field sits at bits 10:7
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH
`define WORD_W        16
`define SEL_BIT       15
`define SCAN_HI       14
`define SCAN_LO       11
`define CHAN_HI       10
`define CHAN_LO       7
`define RSTF_HI       6
`define RSTF_LO       5
`define PM_HI         4
`define PM_LO         3
`define SWCNV_BIT     1
`define RES_W         12
`define BIT_CNT_W     4
`define LAST_BIT      4'hf
`define SCAN_KEEP     4'h0
`define SCAN_MANUAL   4'h1
`define SCAN_REPEAT   4'h2
`define SCAN_STD_INT  4'h3
`define CHAN_RST      4'h0
`define REP_STEP      5'h04
`endif

/* File: include/scan_pkg.sv */
// types shared by the scan-mode decoder files
// assumes scan_params.svh is included by every user
package scan_pkg;
  typedef enum logic [1:0] {mode_manual, mode_repeat, mode_std_int} scan_mode_e;
  typedef enum logic [1:0] {seq_idle, seq_req, seq_wait} seq_state_e;
  typedef logic [3:0] chan_t;
endpackage : scan_pkg

/* File: src/adc_scan_mode_decoder.sv */
// scan-mode decoder: decodes mode-control words from the serial link and
// sequences conversions for manual, repeat and ascending internal scans
// assumes a converter answering conv_req_out with one conv_done_in pulse
`timescale 1ns/1ns
`include "scan_params.svh"
module adc_scan_mode_decoder (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  sclk_in,
  input  wire logic                  cs_b_in,
  input  wire logic                  din_in,
  output logic                       dout_out,
  input  wire logic                  cnv_start_in,
  input  wire logic [1:0]            repeat_sel_in,
  input  wire logic                  conv_done_in,
  input  wire logic [`RES_W-1:0]     conv_data_in,
  output scan_pkg::scan_mode_e       scan_mode_out,
  output scan_pkg::chan_t            chan_sel_out,
  output logic                       clk_src_int_out,
  output logic                       avg_en_out,
  output logic [1:0]                 reset_field_out,
  output logic [1:0]                 pm_out,
  output logic                       swcnv_out,
  output logic                       conv_req_out,
  output scan_pkg::chan_t            conv_chan_out,
  output logic                       fifo_wr_out,
  output logic [`WORD_W-1:0]         fifo_data_out
);
  import scan_pkg::*;

  logic [`WORD_W-1:0] word;
  logic               word_tgl;
  logic [`WORD_W-1:0] result_q, result_d;

  scan_link_port u_link (
    .sclk_in      (sclk_in),
    .rst_b_in     (rst_b_in),
    .cs_b_in      (cs_b_in),
    .din_in       (din_in),
    .load_word_in (result_q),
    .dout_out     (dout_out),
    .word_out     (word),
    .word_tgl_out (word_tgl)
  );

  // word toggle crossing plus start pin synchroniser
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic st_s1_q, st_s2_q, st_s3_q;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      st_s1_q  <= 1'b0;
      st_s2_q  <= 1'b0;
      st_s3_q  <= 1'b0;
    end
    else
    begin
      tgl_s1_q <= word_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      st_s1_q  <= cnv_start_in;
      st_s2_q  <= st_s1_q;
      st_s3_q  <= st_s2_q;
    end
  end

  logic frame_new, is_mode_word, start_pulse;
  logic [3:0] scan_code;
  // word is read only after the toggle has crossed, so it has long settled
  assign frame_new    = tgl_s2_q ^ tgl_s3_q;
  assign is_mode_word = !word[`SEL_BIT];
  assign scan_code    = word[`SCAN_HI:`SCAN_LO];
  assign start_pulse  = st_s2_q & ~st_s3_q;

  function automatic logic known_code(input logic [3:0] code);
    known_code = (code == `SCAN_MANUAL) || (code == `SCAN_REPEAT) ||
                 (code == `SCAN_STD_INT);
  endfunction : known_code

  // mode-control state
  scan_mode_e mode_q, mode_d;
  chan_t      chan_q, chan_d;
  logic [1:0] rstf_q, rstf_d, pm_q, pm_d;
  logic       swcnv_q, swcnv_d;

  always_comb
  begin
    mode_d  = mode_q;
    chan_d  = chan_q;
    rstf_d  = rstf_q;
    pm_d    = pm_q;
    swcnv_d = swcnv_q;
    if (frame_new && is_mode_word)
    begin
      rstf_d  = word[`RSTF_HI:`RSTF_LO];
      pm_d    = word[`PM_HI:`PM_LO];
      swcnv_d = word[`SWCNV_BIT];
      if (scan_code != `SCAN_KEEP && known_code(scan_code))
      begin
        chan_d = word[`CHAN_HI:`CHAN_LO];
        case (scan_code)
          `SCAN_MANUAL:  mode_d = mode_manual;
          `SCAN_REPEAT:  mode_d = mode_repeat;
          `SCAN_STD_INT: mode_d = mode_std_int;
          default:       mode_d = mode_q;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      mode_q  <= mode_manual;
      chan_q  <= `CHAN_RST;
      rstf_q  <= 2'h0;
      pm_q    <= 2'h0;
      swcnv_q <= 1'b0;
    end
    else
    begin
      mode_q  <= mode_d;
      chan_q  <= chan_d;
      rstf_q  <= rstf_d;
      pm_q    <= pm_d;
      swcnv_q <= swcnv_d;
    end
  end

  // conversion sequencer
  seq_state_e      st_q, st_d;
  chan_t           cur_q, cur_d;
  logic [4:0]      done_q, done_d;
  logic            req_q, req_d, wr_q, wr_d;
  logic [`WORD_W-1:0] fdat_q, fdat_d;
  logic [4:0]      rep_total;
  logic            manual_frame, int_start;

  assign rep_total    = 5'((repeat_sel_in + 3'h1) * `REP_STEP);
  assign manual_frame = frame_new && (mode_d == mode_manual);
  assign int_start    = (start_pulse || (frame_new && is_mode_word && word[`SWCNV_BIT]))
                        && (mode_d != mode_manual);

  always_comb
  begin
    st_d     = st_q;
    cur_d    = cur_q;
    done_d   = done_q;
    req_d    = 1'b0;
    wr_d     = 1'b0;
    fdat_d   = fdat_q;
    result_d = result_q;
    case (st_q)
      seq_idle:
      begin
        if (manual_frame)
        begin
          cur_d = chan_d;
          st_d  = seq_req;
        end
        else if (int_start)
        begin
          // repeat holds channel N, standard starts from channel 0
          cur_d  = (mode_d == mode_repeat) ? chan_d : 4'h0;
          done_d = 5'h00;
          st_d   = seq_req;
        end
      end
      seq_req:
      begin
        req_d = 1'b1;
        st_d  = seq_wait;
      end
      seq_wait:
      begin
        if (conv_done_in)
        begin
          if (mode_q == mode_manual)
          begin
            // held for the next frame to shift out
            result_d = {cur_q, conv_data_in};
            st_d     = seq_idle;
          end
          else
          begin
            wr_d   = 1'b1;
            fdat_d = {cur_q, conv_data_in};
            done_d = done_q + 5'h01;
            if (mode_q == mode_repeat)
              st_d = (done_q + 5'h01 >= rep_total) ? seq_idle : seq_req;
            else if (cur_q >= chan_q)
              st_d = seq_idle;
            else
            begin
              cur_d = cur_q + 4'h1;
              st_d  = seq_req;
            end
          end
        end
      end
      default: st_d = seq_idle;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      st_q     <= seq_idle;
      cur_q    <= 4'h0;
      done_q   <= 5'h00;
      req_q    <= 1'b0;
      wr_q     <= 1'b0;
      fdat_q   <= 16'h0000;
      result_q <= 16'h0000;
    end
    else
    begin
      st_q     <= st_d;
      cur_q    <= cur_d;
      done_q   <= done_d;
      req_q    <= req_d;
      wr_q     <= wr_d;
      fdat_q   <= fdat_d;
      result_q <= result_d;
    end
  end

  assign scan_mode_out   = mode_q;
  assign chan_sel_out    = chan_q;
  assign clk_src_int_out = (mode_q != mode_manual);
  assign avg_en_out      = (mode_q != mode_manual);
  assign reset_field_out = rstf_q;
  assign pm_out          = pm_q;
  assign swcnv_out       = swcnv_q;
  assign conv_req_out    = req_q;
  assign conv_chan_out   = cur_q;
  assign fifo_wr_out     = wr_q;
  assign fifo_data_out   = fdat_q;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_keep_word;
    frame_new && is_mode_word && scan_code == `SCAN_KEEP;
  endsequence
  sequence s_manual_frame;
    st_q == seq_idle && manual_frame;
  endsequence
  sequence s_manual_done;
    st_q == seq_wait && mode_q == mode_manual && conv_done_in;
  endsequence
  sequence s_std_start;
    st_q == seq_idle && int_start && mode_d == mode_std_int;
  endsequence

  chk_keep_mode: assert property (s_keep_word |=> $stable(mode_q) && $stable(chan_q))
    else $error("scan mode changed on keep code");
  chk_keep_fields: assert property (s_keep_word |=> pm_q == $past(word[`PM_HI:`PM_LO])
    && swcnv_q == $past(word[`SWCNV_BIT]))
    else $error("fields not updated on keep code");
  chk_keep_reset: assert property (s_keep_word
    |=> rstf_q == $past(word[`RSTF_HI:`RSTF_LO]))
    else $error("reset field not updated on keep code");
  chk_manual_req: assert property (s_manual_frame |-> ##2 conv_req_out
    && conv_chan_out == $past(chan_d, 2))
    else $error("manual frame gave no conversion request");
  chk_manual_hold: assert property (s_manual_done
    |=> result_q == {$past(cur_q), $past(conv_data_in)} && !fifo_wr_out)
    else $error("manual result not held for the next frame");
  chk_manual_clk: assert property (mode_q == mode_manual |-> !clk_src_int_out
    && !avg_en_out && !fifo_wr_out)
    else $error("manual mode used internal clock or averaging");
  chk_repeat_chan: assert property (mode_q == mode_repeat && conv_req_out
    |-> conv_chan_out == chan_q)
    else $error("repeat converted wrong channel");
  chk_repeat_count: assert property (mode_q == mode_repeat && fifo_wr_out
    && st_q == seq_idle |-> done_q == rep_total)
    else $error("repeat scan wrote a wrong number of results");
  chk_repeat_clk: assert property (mode_q == mode_repeat
    |-> clk_src_int_out && avg_en_out)
    else $error("repeat mode not on internal clock");
  chk_std_first: assert property (s_std_start |-> ##2 conv_req_out
    && conv_chan_out == 4'h0)
    else $error("standard scan did not start at channel zero");
  chk_std_order: assert property (mode_q == mode_std_int && st_q == seq_wait
    && conv_done_in && cur_q < chan_q |=> conv_chan_out == $past(conv_chan_out) + 4'h1)
    else $error("standard scan not ascending");
  chk_chan_field: assert property (frame_new && is_mode_word && known_code(scan_code)
    |=> chan_q == $past(word[`CHAN_HI:`CHAN_LO]))
    else $error("channel field not taken");
  chk_sel_bit: assert property (frame_new && word[`SEL_BIT] |=> $stable(mode_q)
    && $stable(pm_q))
    else $error("config word changed mode control");
  chk_code_map: assert property (frame_new && is_mode_word && scan_code == `SCAN_REPEAT
    |=> mode_q == mode_repeat)
    else $error("repeat code not decoded");
endmodule : adc_scan_mode_decoder

/* File: src/scan_link_port.sv */
// serial link front end on the serial clock: shifts control words in,
// shifts the held result word out; the frame signal clears the bit count
// assumes load_word_in stays stable while a frame runs
`timescale 1ns/1ns
`include "scan_params.svh"
module scan_link_port (
  input  wire logic                 sclk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 cs_b_in,
  input  wire logic                 din_in,
  input  wire logic [`WORD_W-1:0]   load_word_in,
  output logic                      dout_out,
  output logic      [`WORD_W-1:0]   word_out,
  output logic                      word_tgl_out
);
  logic [`BIT_CNT_W-1:0] cnt_q, cnt_d;
  logic [`WORD_W-1:0]    rx_q, rx_d, tx_q, tx_d, word_q, word_d;
  logic                  tgl_q, tgl_d;

  always_comb
  begin
    cnt_d  = cnt_q + 4'h1;
    rx_d   = {rx_q[`WORD_W-2:0], din_in};
    tx_d   = (cnt_q == 4'h0) ? {load_word_in[`WORD_W-2:0], 1'b0}
                             : {tx_q[`WORD_W-2:0], 1'b0};
    word_d = word_q;
    tgl_d  = tgl_q;
    if (cnt_q == `LAST_BIT)
    begin
      word_d = rx_d;
      tgl_d  = ~tgl_q;
    end
  end

  // frame end clears the count without needing a clock edge
  always_ff @(posedge sclk_in or posedge cs_b_in)
  begin
    if (cs_b_in)
    begin
      cnt_q <= 4'h0;
      rx_q  <= 16'h0000;
      tx_q  <= 16'h0000;
    end
    else
    begin
      cnt_q <= cnt_d;
      rx_q  <= rx_d;
      tx_q  <= tx_d;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      word_q <= 16'h0000;
      tgl_q  <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      tgl_q  <= tgl_d;
    end
  end

  // first bit goes straight from the held word, later bits from the shifter
  assign dout_out     = (cnt_q == 4'h0) ? load_word_in[`WORD_W-1] : tx_q[`WORD_W-1];
  assign word_out     = word_q;
  assign word_tgl_out = tgl_q;
endmodule : scan_link_port
